// *** test/radio_link_model.sv ***
// Packet engine and TX FIFO model facing the mode controller
`timescale 1ns/10ps
// ****
// Far-side packet handling
// ****
module radio_link_model (
	input wire logic clk_sys, // 50 MHz system clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic upload, // One packet written into the TX FIFO
	input wire logic pkt_start, // Controller starts a packet
	input wire logic [7:0] air_cycles, // Packet plus acks duration
	output logic tx_fifo_empty, // No packet waiting
	output logic tx_done // Packet and acks finished
);
	logic [2:0] depth_r;
	logic [7:0] left_r;
	logic busy_r;
	logic finish;
	// At most 256 cycles on air (air_cycles plus one), far below the open-loop limit
	assign finish = busy_r && left_r == 8'h00;
	assign tx_fifo_empty = depth_r == 3'h0;
	// The packet leaves the queue only when acks end, since a retry resends it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			depth_r <= 3'h0;
			left_r <= 8'h00;
			busy_r <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= finish;
			depth_r <= depth_r + 3'(upload) - 3'(finish);
			if (pkt_start) begin
				busy_r <= 1'b1;
				left_r <= air_cycles;
			end else if (finish) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				left_r <= left_r - 8'h01;
			end
		end
	end
endmodule

// *** test/tb_radio_mode_control.sv ***
// Self-checking bench for the radio mode controller
`timescale 1ns/10ps
`define CHK(g, e) check_val(16'(g), 16'(e))
module tb_radio_mode_control;
	// ****
	// Stimulus, model and checking
	// ****
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	radio_mode_pkg::radio_setup_reg_t setup = '0;
	logic radio_enable = 1'b0, radio_select_n = 1'b1, upload = 1'b0;
	logic rx_pkt_valid = 1'b0, rx_fifo_full = 1'b0, rf_in_channel = 1'b0;
	logic [7:0] air_cycles = 8'h20;
	logic tx_fifo_empty, tx_done, carrier_detect_flag, synth_on, pa_on;
	logic rx_on, fifo_push, pkt_start, rate_2m, lna_hi, osc_ready;
	logic [6:0] mode_out;
	logic [11:0] carrier_mhz;
	logic [3:0] pa_level;
	int err_total = 0, comparisons = 0, cyc = 0, seed;
	radio_mode_control DUT (.clk_sys, .rst, .setup, .radio_enable,
		.radio_select_n, .tx_fifo_empty, .tx_done, .rx_pkt_valid,
		.rx_fifo_full, .rf_in_channel, .mode_out, .carrier_detect_flag,
		.synth_on, .pa_on, .rx_on, .fifo_push, .pkt_start, .rate_2m,
		.lna_hi, .carrier_mhz, .pa_level, .osc_ready);
	radio_link_model link (.clk_sys, .rst, .upload, .pkt_start,
		.air_cycles, .tx_fifo_empty, .tx_done);
	always #10 clk_sys = ~clk_sys;
	// Runs need about 37000 cycles, so 60000 means a hang
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			conclude();
		end
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic check_val(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_mode(input logic [6:0] m, input int lim);
		for (int i = 0; i < lim && mode_out !== m; i++) tick();
		`CHK(mode_out, m);
	endtask
	// Start pulse lasts one cycle, so every cycle is looked at
	task automatic wait_start(input int lim);
		for (int i = 0; i < lim && pkt_start !== 1'b1; i++) tick();
		`CHK(pkt_start, 1'b1);
	endtask
	// Select frames the upload; its rising edge ends it
	task automatic upload_pkt();
		radio_select_n = 1'b0;
		tick();
		upload = 1'b1;
		tick();
		upload = 1'b0;
		radio_select_n = 1'b1;
		tick();
	endtask
	task automatic pulse_rx(input logic full, input logic exp);
		logic seen;
		rx_fifo_full = full;
		rx_pkt_valid = 1'b1;
		tick();
		rx_pkt_valid = 1'b0;
		seen = 1'b0;
		repeat (3) begin
			seen = seen | fifo_push;
			tick();
		end
		`CHK(seen, exp);
		rx_fifo_full = 1'b0;
	endtask
	function automatic logic [11:0] exp_mhz(input logic [6:0] c);
		return 12'h960 + 12'(c);
	endfunction
	function automatic logic [3:0] exp_pa(input logic [1:0] p);
		return {2'h0, p};
	endfunction
	initial begin
		seed = 32'hDA51;
		tick(20);
		rst = 1'b0;
		`CHK(mode_out, radio_mode_pkg::ST_PDOWN);
		`CHK(osc_ready, 1'b0);
		setup.power_on_bit = 1'b1;
		tick();
		`CHK(mode_out, radio_mode_pkg::ST_STARTUP);
		wait_mode(radio_mode_pkg::ST_STBY1, 7500);
		`CHK(osc_ready, 1'b1);
		$display("test powerup done");
		// Every power code and both rate and gain steps, random channels and channel 7E, the top even channel
		for (int k = 0; k < 8; k++) begin
			setup.channel_number = (k == 7) ? 7'h7F : 7'($random(seed));
			// Even channels at 2 Mbps keep neighbours 2MHz apart
			setup.channel_number[0] = setup.channel_number[0] & ~k[2];
			setup.output_power_field = k[1:0];
			setup.air_rate_bit = k[2];
			setup.lna_high_current_bit = k[0];
			tick(2);
			`CHK(carrier_mhz, exp_mhz(setup.channel_number));
			`CHK(pa_level, exp_pa(k[1:0]));
			`CHK(rate_2m, k[2]);
			`CHK(lna_hi, k[0]);
			`CHK(mode_out, radio_mode_pkg::ST_STBY1);
		end
		$display("test setup done");
		pulse_rx(1'b0, 1'b0);
		setup.receive_select_bit = 1'b1;
		radio_enable = 1'b1;
		wait_mode(radio_mode_pkg::ST_RX, 6502);
		`CHK(rx_on, 1'b1);
		pulse_rx(1'b0, 1'b1);
		pulse_rx(1'b1, 1'b0);
		// A one-cycle dropout must restart the carrier filter
		rf_in_channel = 1'b1;
		tick(3000);
		rf_in_channel = 1'b0;
		tick();
		rf_in_channel = 1'b1;
		tick(6390);
		`CHK(carrier_detect_flag, 1'b0);
		tick(20);
		`CHK(carrier_detect_flag, 1'b1);
		rf_in_channel = 1'b0;
		tick(2);
		`CHK(carrier_detect_flag, 1'b0);
		`CHK(mode_out, radio_mode_pkg::ST_RX);
		radio_enable = 1'b0;
		tick();
		`CHK(mode_out, radio_mode_pkg::ST_STBY1);
		$display("test rx done");
		setup.receive_select_bit = 1'b0;
		air_cycles = 8'h14 + 8'($random(seed) & 32'h3F);
		upload_pkt();
		upload_pkt();
		radio_enable = 1'b1;
		wait_start(7010);
		`CHK(mode_out, radio_mode_pkg::ST_TX);
		`CHK(pa_on, 1'b1);
		tick();
		wait_start(300);
		tick();
		wait_mode(radio_mode_pkg::ST_STBY2, 300);
		upload_pkt();
		wait_start(6510);
		`CHK(synth_on, 1'b1);
		setup.power_on_bit = 1'b0;
		tick();
		`CHK(mode_out, radio_mode_pkg::ST_PDOWN);
		`CHK(osc_ready, 1'b0);
		$display("test tx done");
		conclude();
	end
endmodule

// *** verilog/radio_mode_control.sv ***
// Operating-mode controller of the 2.4GHz radio transceiver
`timescale 1ns/10ps
`include "radio_mode_defs.svh"

// Notes on behaviour
// - Power-up from power-down goes to standby-I
// - Enable low returns TX or RX to standby-I
// - Transmitter, enable high, empty FIFO: standby-II
// - Standby keeps settings, config stays usable
// - RX needs power, receive-select, enable all high
// - Valid packet fills free slot, else dropped
// - RX held until controller commands otherwise
// - Carrier flag after 128us persistent signal
// - Transmit needs power, TX role, payload, pulse
// - After packet: enable, FIFO pick next mode
// - Enable high drains whole TX FIFO
// - Standby-II transmits when select rises after upload
// - Power-down to standby within 150us
// - Standby to active, TX-RX swap within 130us
// - One bit picks 1 or 2 Mbps
// - Carrier is 2400 plus channel MHz
// - Power field maps to four output levels
// - One bit picks LNA gain step
// - Receive-select picks receiver or transmitter
// - Reset leaves the radio powered down
// - Power-up cleared powers down from anywhere
module radio_mode_control (
	input wire logic clk_sys, // 50 MHz system clock
	input wire logic rst, // Asynchronous reset, active high
	input wire radio_mode_pkg::radio_setup_reg_t setup, // Configuration bits
	input wire logic radio_enable, // Radio enable bit
	input wire logic radio_select_n, // Radio chip-select, active low
	input wire logic tx_fifo_empty, // TX FIFO holds no packet
	input wire logic tx_done, // Current packet sent, acks done
	input wire logic rx_pkt_valid, // Address matched and CRC good
	input wire logic rx_fifo_full, // No free RX FIFO slot
	input wire logic rf_in_channel, // Raw in-channel RF detect
	output logic [6:0] mode_out, // Current operating mode
	output logic carrier_detect_flag, // Filtered carrier detect
	output logic synth_on, // Synthesizer running
	output logic pa_on, // Transmitter active
	output logic rx_on, // Receiver active
	output logic fifo_push, // Store payload in RX FIFO
	output logic pkt_start, // Begin sending next packet
	output logic rate_2m, // Air rate is 2 Mbps
	output logic lna_hi, // High LNA gain step
	output logic [11:0] carrier_mhz, // Carrier frequency in MHz
	output logic [3:0] pa_level, // Output power step
	output logic osc_ready // Oscillator up, not in power-down or start-up
);
	// ****************************************
	// State
	// ****************************************
	radio_mode_pkg::state_t s_r;
	radio_mode_pkg::state_t s_nxt;
	logic want_rx;
	logic want_tx;
	logic csn_rise;
	logic [15:0] dwell_r;
	logic [15:0] dwell_nxt;

	localparam logic [15:0] PD2STBY = 16'(`PD2STBY_CYC);
	localparam logic [15:0] STBY2ACT = 16'(`STBY2ACT_CYC);
	localparam logic [15:0] CD_CYC = 16'(`CD_FILTER_CYC);
	localparam logic [15:0] CE_CYC = 16'(`CE_PULSE_CYC);

	// Conditions for the active modes
	assign want_rx = setup.power_on_bit & setup.receive_select_bit &
		radio_enable;
	assign want_tx = setup.power_on_bit & ~setup.receive_select_bit;
	assign csn_rise = radio_select_n & ~s_r.csn_prev;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.ce_prev = radio_enable;
		s_nxt.csn_prev = radio_select_n;
		s_nxt.fifo_push = 1'b0;
		s_nxt.pkt_start = 1'b0;
		// Count enable high time; a pulse of more than CE_CYC cycles sends one packet
		if (radio_enable) begin
			if (s_r.ce_cnt < CE_CYC) begin
				s_nxt.ce_cnt = s_r.ce_cnt + 16'h0001;
			end else if (s_r.mode == radio_mode_pkg::ST_STBY1) begin
				s_nxt.ce_long = 1'b1;
			end
		end else begin
			s_nxt.ce_cnt = 16'h0000;
		end
		// A pulse only counts in standby-I; RX or TX time must not arm it
		if (s_r.mode != radio_mode_pkg::ST_STBY1) begin
			s_nxt.ce_long = 1'b0;
		end
		if (s_r.timer != 16'h0000) begin
			s_nxt.timer = s_r.timer - 16'h0001;
		end
		// Mode machine; settings live outside and are never touched here
		case (s_r.mode)
		radio_mode_pkg::ST_PDOWN: begin
			if (setup.power_on_bit) begin
				s_nxt.mode = radio_mode_pkg::ST_STARTUP;
				s_nxt.timer = PD2STBY - 16'h0001;
			end
		end
		radio_mode_pkg::ST_STARTUP: begin
			if (s_r.timer == 16'h0000) begin
				s_nxt.mode = radio_mode_pkg::ST_STBY1;
			end
		end
		radio_mode_pkg::ST_STBY1: begin
			if (want_rx) begin
				s_nxt.mode = radio_mode_pkg::ST_SETTLE;
				s_nxt.settle_rx = 1'b1;
				s_nxt.timer = STBY2ACT - 16'h0001;
			end else if (want_tx && s_r.ce_long && !tx_fifo_empty) begin
				s_nxt.mode = radio_mode_pkg::ST_SETTLE;
				s_nxt.settle_rx = 1'b0;
				s_nxt.timer = STBY2ACT - 16'h0001;
			end else if (want_tx && radio_enable && tx_fifo_empty) begin
				s_nxt.mode = radio_mode_pkg::ST_STBY2;
			end
		end
		radio_mode_pkg::ST_STBY2: begin
			if (!radio_enable || !want_tx) begin
				s_nxt.mode = radio_mode_pkg::ST_STBY1;
			end else if (s_r.upload_seen && !tx_fifo_empty) begin
				s_nxt.mode = radio_mode_pkg::ST_SETTLE;
				s_nxt.settle_rx = 1'b0;
				s_nxt.timer = STBY2ACT - 16'h0001;
			end
		end
		radio_mode_pkg::ST_SETTLE: begin
			if (s_r.timer == 16'h0000 && s_r.settle_rx && !want_rx) begin
				// Receive conditions dropped while settling: back off
				s_nxt.mode = radio_mode_pkg::ST_STBY1;
			end else if (s_r.timer == 16'h0000) begin
				s_nxt.mode = s_r.settle_rx ? radio_mode_pkg::ST_RX :
					radio_mode_pkg::ST_TX;
				s_nxt.pkt_start = ~s_r.settle_rx;
				s_nxt.upload_seen = 1'b0;
			end
		end
		radio_mode_pkg::ST_RX: begin
			// Leaves only on controller command
			if (!radio_enable) begin
				s_nxt.mode = radio_mode_pkg::ST_STBY1;
			end else if (!setup.receive_select_bit) begin
				s_nxt.mode = radio_mode_pkg::ST_SETTLE;
				s_nxt.settle_rx = 1'b0;
				s_nxt.timer = STBY2ACT - 16'h0001;
			end
			if (rx_pkt_valid && !rx_fifo_full) begin
				s_nxt.fifo_push = 1'b1;
			end
		end
		radio_mode_pkg::ST_TX: begin
			// The packet in flight finishes first unless power-up is cleared
			if (tx_done) begin
				s_nxt.ce_long = 1'b0;
				if (!radio_enable) begin
					s_nxt.mode = radio_mode_pkg::ST_STBY1;
				end else if (setup.receive_select_bit) begin
					s_nxt.mode = radio_mode_pkg::ST_SETTLE;
					s_nxt.settle_rx = 1'b1;
					s_nxt.timer = STBY2ACT - 16'h0001;
				end else if (!tx_fifo_empty) begin
					s_nxt.pkt_start = 1'b1;
				end else begin
					s_nxt.mode = radio_mode_pkg::ST_STBY2;
					s_nxt.upload_seen = 1'b0;
				end
			end
		end
		default: begin
			s_nxt.mode = radio_mode_pkg::ST_PDOWN;
		end
		endcase
		// Upload end is taken after the machine so a set beats a clear
		if (csn_rise) begin
			s_nxt.upload_seen = 1'b1;
		end
		// Power-up cleared wins over everything else
		if (!setup.power_on_bit) begin
			s_nxt.mode = radio_mode_pkg::ST_PDOWN;
			s_nxt.timer = 16'h0000;
			s_nxt.fifo_push = 1'b0;
			s_nxt.pkt_start = 1'b0;
		end
		// Carrier filter: counts persistence only while receiving
		if (s_nxt.mode == radio_mode_pkg::ST_RX && rf_in_channel) begin
			if (s_r.cd_cnt < CD_CYC) begin
				s_nxt.cd_cnt = s_r.cd_cnt + 16'h0001;
			end
		end else begin
			s_nxt.cd_cnt = 16'h0000;
		end
		s_nxt.carrier_detect_flag = (s_nxt.cd_cnt >= CD_CYC);
		// Output decode from the next mode keeps outputs registered
		s_nxt.rx_on = (s_nxt.mode == radio_mode_pkg::ST_RX);
		s_nxt.pa_on = (s_nxt.mode == radio_mode_pkg::ST_TX);
		s_nxt.synth_on = (s_nxt.mode == radio_mode_pkg::ST_RX) ||
			(s_nxt.mode == radio_mode_pkg::ST_TX) ||
			(s_nxt.mode == radio_mode_pkg::ST_SETTLE) ||
			(s_nxt.mode == radio_mode_pkg::ST_STBY2);
		s_nxt.ready_out = (s_nxt.mode != radio_mode_pkg::ST_PDOWN) &&
			(s_nxt.mode != radio_mode_pkg::ST_STARTUP);
		s_nxt.rate_2m = setup.air_rate_bit;
		s_nxt.lna_hi = setup.lna_high_current_bit;
		s_nxt.carrier_mhz = `CARRIER_BASE_MHZ +
			{5'h00, setup.channel_number};
		case (setup.output_power_field)
		2'h3: s_nxt.pa_level = radio_mode_pkg::PA_0;
		2'h2: s_nxt.pa_level = radio_mode_pkg::PA_M6;
		2'h1: s_nxt.pa_level = radio_mode_pkg::PA_M12;
		default: s_nxt.pa_level = radio_mode_pkg::PA_M18;
		endcase
		// Cycles spent in the current mode, read only by the bound checks
		if (s_nxt.mode != s_r.mode) begin
			dwell_nxt = 16'h0000;
		end else if (dwell_r != 16'hFFFF) begin
			dwell_nxt = dwell_r + 16'h0001;
		end else begin
			dwell_nxt = dwell_r;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.mode <= radio_mode_pkg::ST_PDOWN;
			s_r.carrier_mhz <= `CARRIER_BASE_MHZ;
			s_r.csn_prev <= 1'b1;
			dwell_r <= 16'h0000;
		end else begin
			s_r <= s_nxt;
			dwell_r <= dwell_nxt;
		end
	end

	assign mode_out = s_r.mode;
	assign carrier_detect_flag = s_r.carrier_detect_flag;
	assign synth_on = s_r.synth_on;
	assign pa_on = s_r.pa_on;
	assign rx_on = s_r.rx_on;
	assign fifo_push = s_r.fifo_push;
	assign pkt_start = s_r.pkt_start;
	assign rate_2m = s_r.rate_2m;
	assign lna_hi = s_r.lna_hi;
	assign carrier_mhz = s_r.carrier_mhz;
	assign pa_level = s_r.pa_level;
	assign osc_ready = s_r.ready_out;

	// ****************************************
	// Checks
	// ****************************************
	AST_PD_START: assert property (@(posedge clk_sys) disable iff (rst)
		s_r.mode == radio_mode_pkg::ST_PDOWN && setup.power_on_bit
		|=> s_r.mode == radio_mode_pkg::ST_STARTUP)
		else $error("power-up did not start oscillator");
	// Transition bounds are held on the dwell counter, not a long delay
	AST_STARTUP_BOUND: assert property (@(posedge clk_sys)
		disable iff (rst) s_r.mode == radio_mode_pkg::ST_STARTUP |->
		dwell_r < PD2STBY)
		else $error("start-up exceeded limit");
	AST_SETTLE_BOUND: assert property (@(posedge clk_sys)
		disable iff (rst) s_r.mode == radio_mode_pkg::ST_SETTLE |->
		dwell_r < STBY2ACT)
		else $error("settling exceeded limit");
	AST_CE_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		s_r.mode == radio_mode_pkg::ST_RX && !radio_enable &&
		setup.power_on_bit |=> s_r.mode == radio_mode_pkg::ST_STBY1)
		else $error("enable low did not leave RX");
	AST_PWR_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!setup.power_on_bit |=> s_r.mode == radio_mode_pkg::ST_PDOWN)
		else $error("power-up low did not power down");
	AST_RX_ENTRY: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(s_r.mode == radio_mode_pkg::ST_RX) |->
		$past(setup.power_on_bit) && s_r.settle_rx)
		else $error("RX entered without conditions");
	AST_DROP_FULL: assert property (@(posedge clk_sys) disable iff (rst)
		rx_fifo_full |=> !fifo_push)
		else $error("payload stored into full FIFO");
	AST_CD_LOW: assert property (@(posedge clk_sys) disable iff (rst)
		!rf_in_channel |=> !carrier_detect_flag)
		else $error("carrier flag without signal");
	AST_STBY2_EMPTY: assert property (@(posedge clk_sys) disable iff (rst)
		s_r.mode == radio_mode_pkg::ST_TX && tx_done && radio_enable &&
		setup.power_on_bit && !setup.receive_select_bit && tx_fifo_empty
		|=> s_r.mode == radio_mode_pkg::ST_STBY2)
		else $error("empty FIFO did not reach standby-II");
	// Entry, start and storage checks
	AST_RX_CONDITIONS: assert property (@(posedge clk_sys)
		disable iff (rst) $rose(rx_on) |->
		$past(setup.receive_select_bit) && $past(radio_enable))
		else $error("RX entered with enable or select low");
	AST_TX_START: assert property (@(posedge clk_sys)
		disable iff (rst) $rose(pa_on) |-> pkt_start)
		else $error("TX entered without a packet start");
	AST_TX_NEXT: assert property (@(posedge clk_sys)
		disable iff (rst) s_r.mode == radio_mode_pkg::ST_TX && tx_done &&
		radio_enable && setup.power_on_bit &&
		!setup.receive_select_bit && !tx_fifo_empty
		|=> pkt_start && s_r.mode == radio_mode_pkg::ST_TX)
		else $error("refilled FIFO did not send next packet");
	AST_PUSH_FREE: assert property (@(posedge clk_sys)
		disable iff (rst) s_r.mode == radio_mode_pkg::ST_RX &&
		rx_pkt_valid && !rx_fifo_full && setup.power_on_bit
		|=> fifo_push)
		else $error("valid packet not stored");
	AST_PUSH_VALID: assert property (@(posedge clk_sys)
		disable iff (rst) fifo_push |->
		$past(rx_pkt_valid) && !$past(rx_fifo_full))
		else $error("store without a valid packet");
	// Carrier flag and copies of the radio settings
	AST_CD_ONLY_RX: assert property (@(posedge clk_sys)
		disable iff (rst) carrier_detect_flag |-> rx_on)
		else $error("carrier flag outside RX");
	AST_CARRIER_FREQ: assert property (@(posedge clk_sys)
		disable iff (rst) carrier_mhz ==
		`CARRIER_BASE_MHZ + {5'h00, $past(setup.channel_number)})
		else $error("carrier frequency does not follow channel");
	AST_PA_MAP: assert property (@(posedge clk_sys)
		disable iff (rst) pa_level ==
		{2'h0, $past(setup.output_power_field)})
		else $error("output power step does not follow field");
	AST_RATE_GAIN: assert property (@(posedge clk_sys)
		disable iff (rst) rate_2m == $past(setup.air_rate_bit) &&
		lna_hi == $past(setup.lna_high_current_bit))
		else $error("rate or gain step does not follow setup");
endmodule

// *** verilog/radio_mode_defs.svh ***
// Constants for the radio operating-mode controller
`ifndef RADIO_MODE_DEFS_SVH
`define RADIO_MODE_DEFS_SVH
`define CLK_PERIOD_NS 20
`define PD2STBY_TIME_NS 150000
`define PD2STBY_CYC ((`PD2STBY_TIME_NS) / (`CLK_PERIOD_NS))
`define STBY2ACT_TIME_NS 130000
`define STBY2ACT_CYC ((`STBY2ACT_TIME_NS) / (`CLK_PERIOD_NS))
`define CD_FILTER_TIME_NS 128000
`define CD_FILTER_CYC \
	(((`CD_FILTER_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CE_PULSE_TIME_NS 10000
`define CE_PULSE_CYC \
	(((`CE_PULSE_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CARRIER_BASE_MHZ 12'h960
`define CHAN_RESET 7'h02
`define PWR_RESET 2'h3
`define TIMER_W 16
`endif

// *** verilog/radio_mode_pkg.sv ***
// Types shared by the radio operating-mode controller
package radio_mode_pkg;
	typedef enum logic [6:0] {
		ST_PDOWN = 7'h01,
		ST_STARTUP = 7'h02,
		ST_STBY1 = 7'h04,
		ST_STBY2 = 7'h08,
		ST_SETTLE = 7'h10,
		ST_RX = 7'h20,
		ST_TX = 7'h40
	} mode_t;

	typedef enum logic [3:0] {
		PA_M18 = 4'h0,
		PA_M12 = 4'h1,
		PA_M6 = 4'h2,
		PA_0 = 4'h3
	} pa_level_t;

	typedef struct packed {
		logic power_on_bit;
		logic receive_select_bit;
		logic air_rate_bit;
		logic lna_high_current_bit;
		logic [1:0] output_power_field;
		logic [6:0] channel_number;
	} radio_setup_reg_t;

	typedef struct packed {
		mode_t mode;
		logic settle_rx;
		logic [15:0] timer;
		logic [15:0] cd_cnt;
		logic [15:0] ce_cnt;
		logic ce_long;
		logic ce_prev;
		logic csn_prev;
		logic upload_seen;
		logic carrier_detect_flag;
		logic synth_on;
		logic pa_on;
		logic rx_on;
		logic fifo_push;
		logic pkt_start;
		logic rate_2m;
		logic lna_hi;
		logic [11:0] carrier_mhz;
		logic [3:0] pa_level;
		logic ready_out;
	} state_t;
endpackage
